//--- verilog/input_fifo_ctrl.v
// Input elastic buffer, pointer sync routing and sample clock control
`timescale 1ns/100ps
`include "fifo_ctrl_regs.vh"

module input_fifo_ctrl (
    input wire sys_clk,
    input wire srst,
    input wire buffer_enable,
    input wire [3:0] wr_sync_select,
    input wire [3:0] rd_sync_select,
    input wire [2:0] read_offset,
    input wire serial_sync,
    input wire synth_enable,
    input wire synth_sleep,
    input wire [2:0] prescaler_code,
    input wire [5:0] coarse_tune,
    input wire [7:0] ref_divider,
    input wire [1:0] charge_pump_select,
    input wire input_data_clock,
    input wire conversion_clock,
    input wire frame_strobe,
    input wire sync_strobe,
    input wire output_strobe,
    input wire [15:0] in_data,
    output reg [63:0] sample_out_q,
    output reg sample_valid_q,
    output reg frame_fwd_q,
    output reg sync_fwd_q,
    output reg [1:0] buffer_mode_q,
    output reg synth_clock_q,
    output reg synth_power_q,
    output reg [5:0] vco_tune_q,
    output reg cp_on_q,
    output reg cp_double_q,
    output reg pfd_strobe_q,
    output reg word_overflow_q,
    output reg [2:0] wr_ptr_q,
    output reg [2:0] rd_ptr_q
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg [`PIN_W-1:0] pin_meta_q;
    reg [`PIN_W-1:0] pin_sync_q;
    reg dclk_prev_q;
    reg conv_prev_q;
    reg frame_lat_q;
    reg sync_lat_q;
    reg output_strobe_lat_q;
    reg sif_pend_q;
    reg buf_en_q;
    reg [3:0] wr_sel_q;
    reg [3:0] rd_sel_q;
    reg [2:0] offset_q;
    reg synth_en_q;
    reg sleep_q;
    reg [2:0] pre_q;
    reg [7:0] mdiv_q;
    reg [2:0] pre_cnt_q;
    reg [7:0] m_cnt_q;
    reg push_v_q;
    reg [16:0] push_d_q;
    reg [63:0] asm_q;
    reg [1:0] idx_q;
    reg asm_rst_q;
    reg [63:0] hold_q;
    reg hold_full_q;
    reg hold_rst_q;
    reg rd_pend_q;
    reg [63:0] mem [0:`BUF_DEPTH-1];
    wire [15:0] s_data;
    wire s_dclk;
    wire s_frame;
    wire s_sync;
    wire s_output_strobe;
    wire s_conv;
    wire dclk_rise;
    wire dclk_fall;
    wire frame_rise;
    wire sync_rise;
    wire wr_evt;
    wire rd_evt_wr;
    wire direct_mode;
    wire synth_mode;
    wire tick;
    wire pfd_tick;
    wire output_strobe_rise;
    wire rd_evt;
    wire dual_mode;
    wire single_mode;
    wire fifo_ready;
    wire [16:0] fifo_data;
    wire fifo_valid;
    wire pop;
    wire wr_en;
    wire [2:0] wr_addr;
    wire [2:0] rd_addr;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two flops on every data, clock and strobe pin from outside the clock domain, except serial_sync
    always @(posedge sys_clk) begin
        pin_meta_q <= {conversion_clock, output_strobe, sync_strobe,
            frame_strobe, input_data_clock, in_data};
        pin_sync_q <= pin_meta_q;
    end
    assign s_data = pin_sync_q[15:0];
    assign s_dclk = pin_sync_q[16];
    assign s_frame = pin_sync_q[17];
    assign s_sync = pin_sync_q[18];
    assign s_output_strobe = pin_sync_q[19];
    assign s_conv = pin_sync_q[20];

    // ------------------------------------------------------------
    // Configuration flops
    // ------------------------------------------------------------
    // Settings captured before they steer routing or clocking
    always @(posedge sys_clk) begin
        if (srst) begin
            buf_en_q <= 1'b0;
            wr_sel_q <= `SEL_NONE;
            rd_sel_q <= `SEL_NONE;
            offset_q <= `RD_OFFSET_INIT;
            synth_en_q <= 1'b0;
            sleep_q <= 1'b1;
            pre_q <= `PRESCALE_INIT;
            mdiv_q <= `MDIV_INIT;
        end else begin
            buf_en_q <= buffer_enable;
            wr_sel_q <= wr_sync_select;
            rd_sel_q <= rd_sync_select;
            offset_q <= read_offset;
            synth_en_q <= synth_enable;
            sleep_q <= synth_sleep;
            pre_q <= prescaler_code;
            mdiv_q <= ref_divider;
        end
    end

    // Mode decode from buffer enable and read select; clock mode from synth enable and sleep
    assign dual_mode = buf_en_q & rd_sel_q[`SEL_OUTPUT_STROBE] &
        ~rd_sel_q[`SEL_SIF] & ~rd_sel_q[`SEL_FRAME] & ~rd_sel_q[`SEL_SYNC];
    assign single_mode = buf_en_q & ~rd_sel_q[`SEL_OUTPUT_STROBE] &
        (rd_sel_q[`SEL_FRAME] | rd_sel_q[`SEL_SYNC]);
    assign direct_mode = ~synth_en_q & sleep_q;
    assign synth_mode = synth_en_q & ~sleep_q;

    // ------------------------------------------------------------
    // Write side: input data clock edges
    // ------------------------------------------------------------
    assign dclk_rise = s_dclk & ~dclk_prev_q;
    assign dclk_fall = ~s_dclk & dclk_prev_q;
    assign frame_rise = dclk_rise & s_frame & ~frame_lat_q;
    assign sync_rise = dclk_rise & s_sync & ~sync_lat_q;
    assign wr_evt = (frame_rise & wr_sel_q[`SEL_FRAME]) |
        (sync_rise & wr_sel_q[`SEL_SYNC]) |
        (dclk_rise & sif_pend_q & wr_sel_q[`SEL_SIF]);
    assign rd_evt_wr = buf_en_q & ~rd_sel_q[`SEL_OUTPUT_STROBE] &
        ((frame_rise & rd_sel_q[`SEL_FRAME]) |
        (sync_rise & rd_sel_q[`SEL_SYNC]) |
        (sif_pend_q & rd_sel_q[`SEL_SIF]));

    // Strobes latched only on input clock rising edges
    always @(posedge sys_clk) begin
        if (srst) begin
            dclk_prev_q <= 1'b0;
            frame_lat_q <= 1'b0;
            sync_lat_q <= 1'b0;
            sif_pend_q <= 1'b0;
            push_v_q <= 1'b0;
            push_d_q <= 17'h00000;
            word_overflow_q <= 1'b0;
        end else begin
            dclk_prev_q <= s_dclk;
            if (dclk_rise) begin
                frame_lat_q <= s_frame;
                sync_lat_q <= s_sync;
            end
            sif_pend_q <= serial_sync | (sif_pend_q & ~dclk_rise);
            push_v_q <= dclk_rise | dclk_fall;
            push_d_q <= {wr_evt, s_data};
            if (push_v_q && !fifo_ready) begin
                word_overflow_q <= 1'b1; // Sticky: source outran drain
            end
        end
    end

    // Word staging buffer between capture and sample assembly
    stage_fifo #(
        .WIDTH(17),
        .DEPTH(`STAGE_DEPTH),
        .AW(2)
    ) u_stage (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_data(push_d_q),
        .in_valid(push_v_q),
        .in_ready(fifo_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(~hold_full_q)
    );
    assign pop = fifo_valid & ~hold_full_q;

    // ------------------------------------------------------------
    // Sample assembly and hold
    // ------------------------------------------------------------
    // Four words per sample, channel A first; tagged word restarts
    always @(posedge sys_clk) begin
        if (srst) begin
            asm_q <= 64'h0000000000000000;
            idx_q <= 2'h0;
            asm_rst_q <= 1'b0;
            hold_q <= 64'h0000000000000000;
            hold_full_q <= 1'b0;
            hold_rst_q <= 1'b0;
        end else begin
            if (pop) begin
                if (fifo_data[16]) begin
                    asm_q[63:48] <= fifo_data[15:0];
                    idx_q <= 2'h1;
                    asm_rst_q <= 1'b1;
                end else if (idx_q == 2'h3) begin
                    hold_q <= {asm_q[63:16], fifo_data[15:0]};
                    hold_full_q <= 1'b1;
                    hold_rst_q <= asm_rst_q;
                    asm_rst_q <= 1'b0;
                    idx_q <= 2'h0;
                end else begin
                    asm_q[63-idx_q*16 -: 16] <= fifo_data[15:0];
                    idx_q <= idx_q + 2'h1;
                end
            end else if (hold_full_q && (buf_en_q || tick)) begin
                hold_full_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Sample clock: direct input or synthesizer
    // ------------------------------------------------------------
    assign tick = (direct_mode & s_conv & ~conv_prev_q) |
        (synth_mode & (({1'b0, pre_cnt_q} + 4'h1) >= {1'b0, pre_q}));
    assign pfd_tick = tick & synth_mode &
        (({1'b0, m_cnt_q} + 9'h001) >= {1'b0, mdiv_q});

    // Prescale and loop dividers count the multiplied clock
    always @(posedge sys_clk) begin
        if (srst) begin
            conv_prev_q <= 1'b0;
            pre_cnt_q <= 3'h0;
            m_cnt_q <= 8'h00;
            pfd_strobe_q <= 1'b0;
            synth_clock_q <= 1'b0;
            synth_power_q <= 1'b0;
            vco_tune_q <= `TUNE_INIT;
            cp_on_q <= 1'b0;
            cp_double_q <= 1'b0;
        end else begin
            conv_prev_q <= s_conv;
            if (!synth_mode || tick) begin
                pre_cnt_q <= 3'h0;
            end else begin
                pre_cnt_q <= pre_cnt_q + 3'h1;
            end
            if (!synth_mode || pfd_tick) begin
                m_cnt_q <= 8'h00;
            end else if (tick) begin
                m_cnt_q <= m_cnt_q + 8'h01;
            end
            pfd_strobe_q <= pfd_tick;
            synth_clock_q <= synth_mode;
            synth_power_q <= ~sleep_q;
            vco_tune_q <= coarse_tune;
            cp_on_q <= (charge_pump_select == `CP_SINGLE) |
                (charge_pump_select == `CP_DOUBLE);
            cp_double_q <= (charge_pump_select == `CP_DOUBLE);
        end
    end

    // ------------------------------------------------------------
    // Read pointer reset sources
    // ------------------------------------------------------------
    assign output_strobe_rise = tick & s_output_strobe & ~output_strobe_lat_q;
    assign rd_evt = rd_evt_wr | (dual_mode & rd_sel_q[`SEL_OUTPUT_STROBE] &
        (synth_mode ? pfd_tick : output_strobe_rise));

    // Pending read reset; a new event wins over its consumption
    always @(posedge sys_clk) begin
        if (srst) begin
            output_strobe_lat_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else begin
            if (tick) begin
                output_strobe_lat_q <= s_output_strobe;
            end
            rd_pend_q <= (rd_pend_q & ~(tick & buf_en_q)) |
                (rd_evt & buf_en_q);
        end
    end

    // ------------------------------------------------------------
    // Sample buffer, eight entries
    // ------------------------------------------------------------
    assign wr_en = buf_en_q & hold_full_q & ~pop;
    assign wr_addr = hold_rst_q ? `WR_PTR_INIT : wr_ptr_q;
    assign rd_addr = rd_pend_q ? offset_q : rd_ptr_q;

    genvar e;
    generate
        for (e = 0; e < `BUF_DEPTH; e = e + 1) begin : g_buf
            always @(posedge sys_clk) begin
                if (wr_en && wr_addr == e[2:0]) begin
                    mem[e] <= hold_q;
                end
            end
        end
    endgenerate

    // Pointers, read port and downstream strobes
    always @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_q <= `WR_PTR_INIT;
            rd_ptr_q <= `RD_OFFSET_INIT;
            sample_out_q <= 64'h0000000000000000;
            sample_valid_q <= 1'b0;
            frame_fwd_q <= 1'b0;
            sync_fwd_q <= 1'b0;
            buffer_mode_q <= `MODE_BYPASS;
        end else begin
            if (wr_en) begin
                wr_ptr_q <= wr_addr + 3'h1;
            end
            sample_valid_q <= 1'b0;
            if (tick && buf_en_q) begin
                sample_out_q <= mem[rd_addr];
                rd_ptr_q <= rd_addr + 3'h1;
                sample_valid_q <= 1'b1;
            end else if (tick && hold_full_q && !pop) begin
                sample_out_q <= hold_q;
                sample_valid_q <= 1'b1;
            end
            frame_fwd_q <= buf_en_q & frame_lat_q;
            sync_fwd_q <= buf_en_q & sync_lat_q;
            if (!buf_en_q) begin
                buffer_mode_q <= `MODE_BYPASS;
            end else if (dual_mode) begin
                buffer_mode_q <= `MODE_DUAL;
            end else if (single_mode) begin
                buffer_mode_q <= `MODE_SINGLE;
            end else begin
                buffer_mode_q <= `MODE_NONE;
            end
        end
    end
endmodule

//--- verilog/fifo_ctrl_regs.vh
// Constants for the input buffer, sync routing and sample clock control
`ifndef FIFO_CTRL_REGS_VH
`define FIFO_CTRL_REGS_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define WORD_W 16
`define SAMPLE_W 64
`define BUF_DEPTH 8
`define PTR_W 3
`define STAGE_DEPTH 4
`define PIN_W 21

// ----------------------------------------------------------------
// Sync select bit positions (both selects)
// ----------------------------------------------------------------
`define SEL_SIF 3
`define SEL_OUTPUT_STROBE 2
`define SEL_FRAME 1
`define SEL_SYNC 0

// ----------------------------------------------------------------
// Buffer modes reported on buffer_mode_q
// ----------------------------------------------------------------
`define MODE_BYPASS 2'h0
`define MODE_DUAL 2'h1
`define MODE_SINGLE 2'h2
`define MODE_NONE 2'h3

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define WR_PTR_INIT 3'h0
`define RD_OFFSET_INIT 3'h4
`define PRESCALE_INIT 3'h1
`define MDIV_INIT 8'h04
`define TUNE_INIT 6'h00
`define CP_SINGLE 2'h1
`define CP_DOUBLE 2'h3
`define SEL_NONE 4'h0
`endif

//--- verilog/stage_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module stage_fifo #(
    parameter WIDTH = 17,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire sys_clk,
    input wire srst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    // Honest full and empty from the occupancy count
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rp_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage entries, one per index
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            always @(posedge sys_clk) begin
                if (push && wp_q == i[AW-1:0]) begin
                    mem[i] <= in_data;
                end
            end
        end
    endgenerate

    // Pointers and count
    always @(posedge sys_clk) begin
        if (srst) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

//--- tb/input_fifo_chk.sv
// Concurrent checks on the buffer mode and clock control ports
`timescale 1ns/100ps
`include "fifo_ctrl_regs.vh"
module input_fifo_chk (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic buffer_enable,
    input wire logic [3:0] rd_sync_select,
    input wire logic synth_enable,
    input wire logic synth_sleep,
    input wire logic [5:0] coarse_tune,
    input wire logic [1:0] charge_pump_select,
    input wire logic [1:0] buffer_mode_q,
    input wire logic frame_fwd_q,
    input wire logic sync_fwd_q,
    input wire logic synth_clock_q,
    input wire logic synth_power_q,
    input wire logic [5:0] vco_tune_q,
    input wire logic cp_on_q,
    input wire logic cp_double_q,
    input wire logic pfd_strobe_q
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // ------------------------------------------------
    // Mode decode
    // ------------------------------------------------
    wire logic dual_in;
    wire logic single_in;
    wire logic direct_in;
    wire logic synth_in;
    assign dual_in = buffer_enable && rd_sync_select == 4'h4;
    assign single_in = buffer_enable &&
        (rd_sync_select == 4'h1 || rd_sync_select == 4'h2);
    assign direct_in = !synth_enable && synth_sleep;
    assign synth_in = synth_enable && !synth_sleep;
    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    bypass_mode_a: assert property (
        !buffer_enable [*4] |-> buffer_mode_q == `MODE_BYPASS)
        else $error("buffer mode not bypass");
    dual_mode_a: assert property (
        dual_in [*4] |-> buffer_mode_q == `MODE_DUAL)
        else $error("buffer mode not dual");
    single_mode_a: assert property (
        single_in [*4] |-> buffer_mode_q == `MODE_SINGLE)
        else $error("buffer mode not single");
    strobe_block_a: assert property (
        !buffer_enable [*4] |=> !frame_fwd_q && !sync_fwd_q)
        else $error("strobe forwarded in bypass");
    direct_clock_a: assert property (
        direct_in [*4] |-> !synth_clock_q && !synth_power_q)
        else $error("direct clock not selected");
    synth_clock_a: assert property (
        synth_in [*4] |-> synth_clock_q && synth_power_q)
        else $error("synth clock not selected");
    tune_copy_a: assert property (
        $stable(coarse_tune) [*4] |-> vco_tune_q == coarse_tune)
        else $error("coarse tune not applied");
    cp_double_a: assert property (
        (charge_pump_select == `CP_DOUBLE) [*4] |-> cp_on_q && cp_double_q)
        else $error("double pump not set");
    cp_single_a: assert property (
        (charge_pump_select == `CP_SINGLE) [*4] |-> cp_on_q && !cp_double_q)
        else $error("single pump not set");
    pfd_quiet_a: assert property (
        direct_in [*4] |=> !pfd_strobe_q)
        else $error("loop strobe outside synth mode");
    // Main scenarios reached
    dual_seen_c: cover property (buffer_mode_q == `MODE_DUAL);
    single_seen_c: cover property (buffer_mode_q == `MODE_SINGLE);
    pfd_seen_c: cover property (pfd_strobe_q);
endmodule

bind input_fifo_ctrl input_fifo_chk u_chk (
    .sys_clk, .srst, .buffer_enable, .rd_sync_select, .synth_enable,
    .synth_sleep, .coarse_tune, .charge_pump_select, .buffer_mode_q,
    .frame_fwd_q, .sync_fwd_q, .synth_clock_q, .synth_power_q,
    .vco_tune_q, .cp_on_q, .cp_double_q, .pfd_strobe_q
);

//--- tb/data_source_model.sv
// Behavioural data source: input clock, strobes and data words
`timescale 1ns/100ps
module data_source_model (
    output logic input_data_clock,
    output logic frame_strobe,
    output logic sync_strobe,
    output logic [15:0] in_data
);
    // Idle: clock parked low, strobes low
    initial begin
        input_data_clock = 1'h0;
        frame_strobe = 1'h0;
        sync_strobe = 1'h0;
        in_data = 16'h0000;
    end
    // One sample as four words, A at the rising edge; the clock runs
    // only inside bursts
    task automatic send(input logic [63:0] s, input logic fr,
            input logic sy);
        int i;
        for (i = 0; i < 4; i++) begin
            in_data = s[63 - 16 * i -: 16];
            if (i == 0) begin
                frame_strobe = fr;
                sync_strobe = sy;
            end
            #10 input_data_clock = ~input_data_clock;
            #10;
            if (i == 1) begin
                frame_strobe = 1'h0;
                sync_strobe = 1'h0;
            end
        end
    endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the input buffer and clock control block
`timescale 1ns/100ps
module testbench;
    // ------------------------------------------------
    // Configuration rows and expected outputs
    // ------------------------------------------------
    typedef struct packed {
        logic en;
        logic [3:0] rd;
        logic se;
        logic sl;
        logic [1:0] cp;
        logic [5:0] tune;
        logic [1:0] mode;
        logic sclk;
        logic on;
        logic dbl;
    } row_t;
    row_t rows[6] = '{
        '{1'h0, 4'h4, 1'h0, 1'h1, 2'h1, 6'h00, 2'h0, 1'h0, 1'h1, 1'h0},
        '{1'h1, 4'h4, 1'h1, 1'h0, 2'h3, 6'h3F, 2'h1, 1'h1, 1'h1, 1'h1},
        '{1'h1, 4'h2, 1'h0, 1'h1, 2'h0, 6'h15, 2'h2, 1'h0, 1'h0, 1'h0},
        '{1'h1, 4'h1, 1'h1, 1'h0, 2'h2, 6'h2A, 2'h2, 1'h1, 1'h0, 1'h0},
        '{1'h1, 4'h0, 1'h0, 1'h1, 2'h1, 6'h01, 2'h3, 1'h0, 1'h1, 1'h0},
        '{1'h0, 4'hF, 1'h1, 1'h0, 2'h3, 6'h20, 2'h0, 1'h1, 1'h1, 1'h1}};
    // Divider pairs, product kept within 24 to 120
    logic [2:0] pv[2] = '{3'h7, 3'h3};
    logic [7:0] mv[2] = '{8'h04, 8'h08};
    logic sys_clk = 1'h0;
    logic srst = 1'h1;
    logic buffer_enable = 1'h0;
    logic [3:0] wr_sync_select = 4'h0;
    logic [3:0] rd_sync_select = 4'h0;
    logic [2:0] read_offset = 3'h4;
    logic serial_sync = 1'h0;
    logic synth_enable = 1'h0;
    logic synth_sleep = 1'h1;
    logic [2:0] prescaler_code = 3'h1;
    logic [5:0] coarse_tune = 6'h00;
    logic [7:0] ref_divider = 8'h04;
    logic [1:0] charge_pump_select = 2'h1;
    logic conversion_clock = 1'h0;
    logic output_strobe = 1'h0;
    logic conv_run = 1'h1;
    logic [3:0] conv_cnt = 4'h0;
    logic fwd_seen = 1'h0;
    logic [63:0] got[$];
    int failures = 0;
    int num_checks = 0;
    wire logic input_data_clock;
    wire logic frame_strobe;
    wire logic sync_strobe;
    wire logic [15:0] in_data;
    wire logic [63:0] sample_out_q;
    wire logic sample_valid_q, frame_fwd_q, sync_fwd_q, synth_clock_q;
    wire logic synth_power_q, cp_on_q, cp_double_q, pfd_strobe_q;
    wire logic word_overflow_q;
    wire logic [1:0] buffer_mode_q;
    wire logic [5:0] vco_tune_q;
    wire logic [2:0] wr_ptr_q, rd_ptr_q;

    input_fifo_ctrl u_dut (
        .sys_clk, .srst, .buffer_enable, .wr_sync_select, .rd_sync_select,
        .read_offset, .serial_sync, .synth_enable, .synth_sleep,
        .prescaler_code, .coarse_tune, .ref_divider, .charge_pump_select,
        .input_data_clock, .conversion_clock, .frame_strobe, .sync_strobe,
        .output_strobe, .in_data, .sample_out_q, .sample_valid_q,
        .frame_fwd_q, .sync_fwd_q, .buffer_mode_q, .synth_clock_q,
        .synth_power_q, .vco_tune_q, .cp_on_q, .cp_double_q, .pfd_strobe_q,
        .word_overflow_q, .wr_ptr_q, .rd_ptr_q
    );
    data_source_model u_src (
        .input_data_clock, .frame_strobe, .sync_strobe, .in_data
    );

    // ------------------------------------------------
    // Clocks and capture
    // ------------------------------------------------
    always #2.5 sys_clk = ~sys_clk;
    // Sample clock at one sample per 16 cycles, can be stalled
    always @(posedge sys_clk) begin
        conv_cnt <= conv_cnt + 4'h1;
        if (conv_run) conversion_clock <= conv_cnt[3];
    end
    // Record delivered samples and forwarded frame strobes
    always @(posedge sys_clk) begin
        if (sample_valid_q === 1'h1) got.push_back(sample_out_q);
        if (frame_fwd_q === 1'h1) fwd_seen <= 1'h1;
    end

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [63:0] smp(input logic [7:0] i);
        smp = {8'hA0, i, 8'hB0, i, 8'hC0, i, 8'hD0, i};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Count edges up to the next loop divider strobe
    task automatic wait_pfd(output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pfd_strobe_q !== 1'h1 && n < 1000);
        if (n >= 1000) begin
            failures++;
            report_and_stop;
        end
    endtask
    // Send n samples off the edge, strobes only on sample index at
    task automatic burst(input int n, input int at, input logic fr,
            input logic sy);
        int i;
        #1;
        for (i = 0; i < n; i++)
            u_src.send(smp(8'(i)), fr && i == at, sy && i == at);
        u_src.in_data = ~u_src.in_data; // Released bus shows junk
    endtask
    // Stream 16 samples and look for the first 10 in order at the output
    task automatic stream(input logic dual);
        int i;
        int j;
        got.delete();
        if (dual) output_strobe <= 1'h1;
        burst(16, 0, 1'h1, 1'h0);
        cyc(60);
        output_strobe <= 1'h0;
        j = 0;
        while (j < got.size() && got[j] !== smp(8'h00)) j++;
        for (i = 0; i < 10; i++) check(got[j + i], smp(8'(i)));
    endtask
    // Reset, write three samples, then a strobed fourth
    task automatic ptr_case(input logic [3:0] ws, input logic fr,
            input logic sy, input logic [2:0] exp);
        @(posedge sys_clk);
        srst <= 1'h1;
        wr_sync_select <= ws;
        rd_sync_select <= 4'h0;
        buffer_enable <= 1'h1;
        cyc(3);
        check(rd_ptr_q, 3'h4);
        check(wr_ptr_q, 3'h0);
        srst <= 1'h0;
        cyc(4);
        burst(4, 3, fr, sy);
        cyc(12);
        check(wr_ptr_q, exp);
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        int k;
        int n;
        cyc(10);
        srst <= 1'h0;
        cyc(4);
        for (k = 0; k < 6; k++) begin
            @(posedge sys_clk);
            buffer_enable <= rows[k].en;
            rd_sync_select <= rows[k].rd;
            synth_enable <= rows[k].se;
            synth_sleep <= rows[k].sl;
            charge_pump_select <= rows[k].cp;
            coarse_tune <= rows[k].tune;
            cyc(5);
            check(buffer_mode_q, rows[k].mode);
            check(synth_clock_q, rows[k].sclk);
            check(synth_power_q, !rows[k].sl);
            check(vco_tune_q, rows[k].tune);
            check(cp_on_q, rows[k].on);
            check(cp_double_q, rows[k].dbl);
        end
        for (k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            prescaler_code <= pv[k];
            ref_divider <= mv[k];
            cyc(8);
            wait_pfd(n);
            wait_pfd(n);
            check(n, pv[k] * mv[k]);
        end
        @(posedge sys_clk);
        synth_enable <= 1'h0;
        synth_sleep <= 1'h1;
        buffer_enable <= 1'h0;
        wr_sync_select <= 4'h2;
        rd_sync_select <= 4'h2;
        cyc(5);
        stream(1'h0);
        check(fwd_seen, 1'h0);
        check(word_overflow_q, 1'h0);
        buffer_enable <= 1'h1;
        cyc(5);
        stream(1'h0);
        check(fwd_seen, 1'h1);
        rd_sync_select <= 4'h4;
        read_offset <= 3'h5;
        cyc(5);
        stream(1'h1);
        // Stall the sample side in bypass until words are refused
        buffer_enable <= 1'h0;
        conv_run <= 1'h0;
        cyc(5);
        burst(3, 0, 1'h0, 1'h0);
        cyc(8);
        check(word_overflow_q, 1'h1);
        conv_run <= 1'h1;
        ptr_case(4'h2, 1'h1, 1'h0, 3'h1);
        ptr_case(4'h1, 1'h0, 1'h1, 3'h1);
        ptr_case(4'h1, 1'h1, 1'h0, 3'h4);
        ptr_case(4'h0, 1'h1, 1'h1, 3'h4);
        // Software sync pulse tags the next sample to entry 0
        wr_sync_select <= 4'h8;
        serial_sync <= 1'h1;
        @(posedge sys_clk);
        serial_sync <= 1'h0;
        burst(1, 0, 1'h0, 1'h0);
        cyc(12);
        check(wr_ptr_q, 3'h1);
        report_and_stop;
    end
endmodule
